/* File: rtl/lcd_defines.svh */
// Constants of the character display instruction decoder
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH
`define CLK_HZ 40000000
`define T_LONG_NS 1530000
`define T_SHORT_NS 39000
`define T_DATA_NS 43000
`define CYC_LONG ((`T_LONG_NS * 40) / 1000)
`define CYC_SHORT ((`T_SHORT_NS * 40) / 1000)
`define CYC_DATA ((`T_DATA_NS * 40) / 1000)
`define SPACE_CODE 8'h20
`define TEXT_DEPTH 128
`define GLYPH_DEPTH 64
`define RST_DIR 1'b0
`define RST_WIDE 1'b1
`endif

/* File: rtl/lcd_pkg.sv */
// Types shared by the decoder files
package lcd_pkg;
  typedef struct packed {
    logic display_on;
    logic cursor_on;
    logic cursor_blink;
    logic dir_inc;
    logic auto_scroll_on_write;
    logic bus_width_select;
    logic two_line;
    logic big_font;
  } cfg_t;
  typedef struct packed {
    logic register_select;
    logic rd;
    logic [7:0] data;
  } xfer_t;
endpackage : lcd_pkg

/* File: rtl/lcd_bus_port.sv */
// Host bus front end: synchronises pins, assembles nibbles into bytes
`include "lcd_defines.svh"
module lcd_bus_port (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host pins
  input wire logic en_i,
  input wire logic rs_i,
  input wire logic rw_i,
  input wire logic [7:0] db_i,
  // Mode and result
  input wire logic wide_i,
  output lcd_pkg::xfer_t xfer_o,
  output logic xfer_valid_o,
  output logic nib_low_o
);
  logic [2:0] e_s1_q, e_s1_d, e_s2_q, e_s2_d;
  logic [7:0] db_s1_q, db_s2_q;
  logic e_prev_q, e_prev_d, low_q, low_d;
  logic [3:0] hi_q, hi_d;
  lcd_pkg::xfer_t x_q, x_d;
  logic v_q, v_d;
  logic fall;

  always_comb begin
    e_s1_d = {en_i, rs_i, rw_i};
    e_s2_d = e_s1_q;
    e_prev_d = e_s2_q[2];
    fall = e_prev_q & ~e_s2_q[2];
    low_d = low_q;
    hi_d = hi_q;
    x_d = x_q;
    v_d = 1'b0;
    if (fall) begin
      x_d.register_select = e_s2_q[1];
      x_d.rd = e_s2_q[0];
      if (wide_i) begin
        x_d.data = db_s2_q;
        v_d = 1'b1;
        low_d = 1'b0;
      // [R19] High nibble first
      end else if (!low_q) begin
        hi_d = db_s2_q[7:4];
        low_d = 1'b1;
        v_d = e_s2_q[0];
      end else begin
        // [R17] Two nibbles on upper lines
        x_d.data = {hi_q, db_s2_q[7:4]};
        low_d = 1'b0;
        v_d = ~e_s2_q[0];
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      e_s1_q <= 3'h0;
      e_s2_q <= 3'h0;
      db_s1_q <= 8'h00;
      db_s2_q <= 8'h00;
      e_prev_q <= 1'b0;
      low_q <= 1'b0;
      hi_q <= 4'h0;
      x_q <= '0;
      v_q <= 1'b0;
    end else begin
      e_s1_q <= e_s1_d;
      e_s2_q <= e_s2_d;
      db_s1_q <= db_i;
      db_s2_q <= db_s1_q;
      e_prev_q <= e_prev_d;
      low_q <= low_d;
      hi_q <= hi_d;
      x_q <= x_d;
      v_q <= v_d;
    end
  end

  assign xfer_o = x_q;
  assign xfer_valid_o = v_q;
  assign nib_low_o = low_q;
endmodule : lcd_bus_port

/* File: rtl/lcd_decoder.sv */
// Instruction decoder and execution sequencer of a character display
// Function
// [R1] Clear fills spaces, zeroes counter, long busy
// [R2] Home zeroes counter and shift, long busy
// [R3] Entry mode loads direction and scroll
// [R4] Display control loads on, cursor, blink
// [R5] Shift moves cursor or display only
// [R6] Function set loads width, lines, font
// [R7] Glyph address set loads six bits
// [R8] Text address set loads seven bits
// [R9] Status read gives busy and counter
// [R10] Data write stores into targeted memory
// [R11] Data read returns targeted memory byte; the bus shows the data latch, loaded by the previous data read or write
// [R12] Counter steps after each data access
// [R13] Busy high throughout execution
// [R14] Host polls busy before next instruction
// [R15] Host waits half oscillator period
// [R16] Transfers latched into instruction/data latch
// [R17] Four-bit mode uses two upper transfers
// [R18] Direction high increments the counter
// [R19] Upper nibble first, latched on fall
`include "lcd_defines.svh"
module lcd_decoder #(
  parameter int unsigned LONG_CYC = `CYC_LONG,
  parameter int unsigned SHORT_CYC = `CYC_SHORT,
  parameter int unsigned DATA_CYC = `CYC_DATA
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host pins
  input wire logic en_i,
  input wire logic register_select_i,
  input wire logic rw_i,
  input wire logic [7:0] db_i,
  output logic [7:0] db_o,
  output logic db_oe_o,
  // Status
  output lcd_pkg::cfg_t cfg_o,
  output logic busy_flag_o,
  output logic [6:0] address_counter_o,
  output logic [6:0] display_shift_o
);
  if (LONG_CYC < SHORT_CYC || SHORT_CYC == 0 || DATA_CYC == 0) begin : g_bad
    $error("lcd_decoder: bad timing parameters");
  end

  typedef enum logic [1:0] {IDLE, CLEARING, WAITING} st_t;

  // ************************************************
  // Host side
  // ************************************************
  lcd_pkg::xfer_t xfer;
  logic xfer_valid, nib_low, en_s1_q, en_s2_q, en_s3_q;
  // Select pin gets its own two stages so the read mux never sees it raw
  logic rs_s1_q, rs_s2_q;
  lcd_pkg::cfg_t cfg_q, cfg_d;

  lcd_bus_port u_port (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .en_i(en_i),
    .rs_i(register_select_i),
    .rw_i(rw_i),
    .db_i(db_i),
    .wide_i(cfg_q.bus_width_select),
    .xfer_o(xfer),
    .xfer_valid_o(xfer_valid),
    .nib_low_o(nib_low)
  );

  // ************************************************
  // State
  // ************************************************
  logic [7:0] text_mem_q [`TEXT_DEPTH];
  logic [7:0] glyph_mem_q [`GLYPH_DEPTH];
  logic [7:0] instruction_latch_q, instruction_latch_d;
  logic [7:0] data_latch_q, data_latch_d;
  logic [6:0] ac_q, ac_d, shift_q, shift_d;
  logic glyph_sel_q, glyph_sel_d;
  st_t st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [6:0] clr_q, clr_d;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [7:0] out_q, out_d;

  function automatic logic [6:0] step(input logic [6:0] a,
                                      input logic up);
    step = up ? a + 7'h01 : a - 7'h01;
  endfunction : step

  always_comb begin
    rd_byte = glyph_sel_q ? glyph_mem_q[ac_q[5:0]] : text_mem_q[ac_q];
  end

  always_comb begin
    cfg_d = cfg_q;
    instruction_latch_d = instruction_latch_q;
    data_latch_d = data_latch_q;
    ac_d = ac_q;
    shift_d = shift_q;
    glyph_sel_d = glyph_sel_q;
    st_d = st_q;
    cnt_d = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
    clr_d = clr_q;
    wr_en = 1'b0;
    wr_addr = ac_q;
    wr_data = data_latch_q;
    unique case (st_q)
      CLEARING: begin
        // [R1] Space fill loop
        wr_en = 1'b1;
        wr_addr = clr_q;
        wr_data = `SPACE_CODE;
        clr_d = clr_q + 7'h01;
        if (clr_q == 7'h7f) begin
          st_d = WAITING;
        end
      end
      WAITING: begin
        if (cnt_q <= 32'h1) begin
          st_d = IDLE;
        end
      end
      IDLE: begin
      end
    endcase
    // [R9] Status read not gated by busy
    if (xfer_valid && !xfer.rd && st_q == IDLE) begin
      st_d = WAITING;
      cnt_d = SHORT_CYC;
      // [R16] Latch by register select
      if (!xfer.register_select) begin
        instruction_latch_d = xfer.data;
        if (xfer.data[7]) begin
          // [R8] Text address
          ac_d = xfer.data[6:0];
          glyph_sel_d = 1'b0;
        end else if (xfer.data[6]) begin
          // [R7] Glyph address
          ac_d = {1'b0, xfer.data[5:0]};
          glyph_sel_d = 1'b1;
        end else if (xfer.data[5]) begin
          // [R6] Width, lines, font
          cfg_d.bus_width_select = xfer.data[4];
          cfg_d.two_line = xfer.data[3];
          cfg_d.big_font = xfer.data[2];
        end else if (xfer.data[4]) begin
          // [R5] Cursor or display shift
          if (xfer.data[3]) begin
            shift_d = step(shift_q, xfer.data[2]);
          end else begin
            ac_d = step(ac_q, xfer.data[2]);
          end
        end else if (xfer.data[3]) begin
          // [R4] Display control bits
          cfg_d.display_on = xfer.data[2];
          cfg_d.cursor_on = xfer.data[1];
          cfg_d.cursor_blink = xfer.data[0];
        end else if (xfer.data[2]) begin
          // [R3] Entry mode bits
          cfg_d.dir_inc = xfer.data[1];
          cfg_d.auto_scroll_on_write = xfer.data[0];
        end else if (xfer.data[1]) begin
          // [R2] Home
          ac_d = 7'h00;
          shift_d = 7'h00;
          glyph_sel_d = 1'b0;
          cnt_d = LONG_CYC;
        end else if (xfer.data[0]) begin
          // [R1] Clear
          ac_d = 7'h00;
          shift_d = 7'h00;
          glyph_sel_d = 1'b0;
          cfg_d.dir_inc = 1'b1;
          clr_d = 7'h00;
          cnt_d = LONG_CYC;
          st_d = CLEARING;
        end
      end else begin
        // [R10] Data write to target
        data_latch_d = xfer.data;
        wr_en = 1'b1;
        wr_data = xfer.data;
        cnt_d = DATA_CYC;
        // [R12] [R18] Counter step
        ac_d = step(ac_q, cfg_q.dir_inc);
        if (cfg_q.auto_scroll_on_write && !glyph_sel_q) begin
          shift_d = step(shift_q, ~cfg_q.dir_inc);
        end
      end
    end
    // [R11] Data read completes, then steps
    if (xfer_valid && xfer.rd && xfer.register_select && st_q == IDLE) begin
      data_latch_d = rd_byte;
      ac_d = step(ac_q, cfg_q.dir_inc);
      st_d = WAITING;
      cnt_d = DATA_CYC;
    end
  end

  // Read data is sampled at the rising enable so it stands while E is high
  always_comb begin
    out_d = out_q;
    if (en_s2_q && !en_s3_q) begin
      // [R9] Busy on bit 7, counter below
      out_d = rs_s2_q ? data_latch_q : {st_q != IDLE, ac_q};
      if (!cfg_q.bus_width_select && nib_low) begin
        out_d = {out_q[3:0], 4'h0};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= {3'h0, `RST_DIR, 1'b0, `RST_WIDE, 2'h0};
      instruction_latch_q <= 8'h00;
      data_latch_q <= 8'h00;
      ac_q <= 7'h00;
      shift_q <= 7'h00;
      glyph_sel_q <= 1'b0;
      st_q <= IDLE;
      cnt_q <= 32'h0;
      clr_q <= 7'h00;
      out_q <= 8'h00;
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
      en_s3_q <= 1'b0;
      rs_s1_q <= 1'b0;
      rs_s2_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      instruction_latch_q <= instruction_latch_d;
      data_latch_q <= data_latch_d;
      ac_q <= ac_d;
      shift_q <= shift_d;
      glyph_sel_q <= glyph_sel_d;
      st_q <= st_d;
      cnt_q <= cnt_d;
      clr_q <= clr_d;
      out_q <= out_d;
      en_s1_q <= en_i;
      en_s2_q <= en_s1_q;
      en_s3_q <= en_s2_q;
      rs_s1_q <= register_select_i;
      rs_s2_q <= rs_s1_q;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_en) begin
      if (glyph_sel_q && st_q != CLEARING) begin
        glyph_mem_q[wr_addr[5:0]] <= wr_data;
      end else begin
        text_mem_q[wr_addr] <= wr_data;
      end
    end
  end

  // [R13] Busy for whole execution
  assign busy_flag_o = (st_q != IDLE);
  assign db_o = out_q;
  assign db_oe_o = en_i & rw_i;
  assign cfg_o = cfg_q;
  assign address_counter_o = ac_q;
  assign display_shift_o = shift_q;
endmodule : lcd_decoder

/* File: dv/lcd_decoder_asserts.sv */
// Port checks of the display instruction decoder
module lcd_decoder_asserts #(
  parameter int unsigned LONG_CYC = 20,
  parameter int unsigned SHORT_CYC = 20,
  parameter int unsigned DATA_CYC = 20
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // Host pins
  input wire logic en_i,
  input wire logic register_select_i,
  input wire logic rw_i,
  input wire logic [7:0] db_i,
  input wire logic [7:0] db_o,
  input wire logic db_oe_o,
  // Status
  input wire lcd_pkg::cfg_t cfg_o,
  input wire logic busy_flag_o,
  input wire logic [6:0] address_counter_o,
  input wire logic [6:0] display_shift_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Helper counters
  // ****************
  logic [15:0] run_q;
  logic [15:0] run_d;
  logic [3:0] fall_q;
  logic [3:0] fall_d;
  logic en_q;
  always_comb begin
    run_d = busy_flag_o ? run_q + 16'h0001 : 16'h0000;
    fall_d = (en_q && !en_i) ? 4'h0 : fall_q + {3'h0, fall_q != 4'hf};
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_q <= 16'h0000;
      fall_q <= 4'hf;
      en_q <= 1'b0;
    end else begin
      run_q <= run_d;
      fall_q <= fall_d;
      en_q <= en_i;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  a_oe_follows_en: assert property (
    db_oe_o == (en_i && rw_i)) else $error("read enable wrong");
  a_busy_on_write: assert property (
    $fell(en_i) && !rw_i && cfg_o.bus_width_select && !busy_flag_o
    |-> ##[1:8] busy_flag_o) else $error("busy did not rise");
  // Slack of one cycle for the sync stage
  a_busy_length: assert property (
    $fell(busy_flag_o) |-> run_q inside {[SHORT_CYC:SHORT_CYC + 1],
    [DATA_CYC:DATA_CYC + 1], [LONG_CYC:LONG_CYC + 129]})
    else $error("busy length wrong");
  a_busy_cause: assert property (
    $rose(busy_flag_o) |-> fall_q <= 4'h8) else $error("busy uncaused");
  a_status_idle: assert property (
    (!busy_flag_o)[*8] ##0 ($fell(en_i) && rw_i && !register_select_i
    && cfg_o.bus_width_select) |-> db_o == {1'b0, address_counter_o})
    else $error("idle status wrong");
  a_status_busy: assert property (
    busy_flag_o[*8] ##0 ($fell(en_i) && rw_i && !register_select_i
    && cfg_o.bus_width_select) |-> db_o[7]) else $error("busy not shown");
  a_cfg_cause: assert property (
    $changed(cfg_o) |-> $past(busy_flag_o) or ##[0:4] busy_flag_o)
    else $error("settings changed unasked");
  a_ac_cause: assert property (
    $changed(address_counter_o) || $changed(display_shift_o)
    |-> $past(busy_flag_o) or ##[0:4] busy_flag_o)
    else $error("counter changed unasked");
endmodule : lcd_decoder_asserts
bind lcd_decoder lcd_decoder_asserts #(.LONG_CYC(LONG_CYC),
  .SHORT_CYC(SHORT_CYC), .DATA_CYC(DATA_CYC)) u_chk (.mclk_i, .rst_i,
  .en_i, .register_select_i, .rw_i, .db_i, .db_o, .db_oe_o, .cfg_o,
  .busy_flag_o, .address_counter_o, .display_shift_o);

/* File: dv/lcd_host_model.sv */
// Host processor model on the strobed parallel bus
module lcd_host_model #(
  parameter int HALF_OSC = 74
) (
  // Clock
  input wire logic mclk_i,
  // Bus
  input wire logic [7:0] rd_i,
  output logic en_o,
  output logic rs_o,
  output logic rw_o,
  output logic [7:0] wr_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wide = 1'b1;
  int hangs = 0;
  initial begin
    en_o = 1'b0;
    rs_o = 1'b0;
    rw_o = 1'b0;
    wr_o = 8'h00;
  end
  // ************
  // Bus cycles
  // ************
  // Taken at strobe fall; no pull, so released lines flip
  task automatic strobe(input logic rs, rw, input logic [7:0] v,
      output logic [7:0] r);
    @(posedge mclk_i);
    rs_o <= rs;
    rw_o <= rw;
    wr_o <= rw ? ~wr_o : v;
    @(posedge mclk_i);
    en_o <= 1'b1;
    repeat (6) @(posedge mclk_i);
    r = rd_i;
    en_o <= 1'b0;
    @(posedge mclk_i);
    wr_o <= ~wr_o;
    repeat (4) @(posedge mclk_i);
  endtask : strobe
  task automatic xfer(input logic rs, rw, input logic [7:0] v,
      output logic [7:0] r);
    logic [7:0] h;
    logic [7:0] l;
    if (wide) begin
      strobe(rs, rw, v, r);
    end else begin
      strobe(rs, rw, v, h);
      strobe(rs, rw, {v[3:0], 4'h0}, l);
      r = {h[7:4], l[7:4]};
    end
  endtask : xfer
  // Poll busy, then half an oscillator period
  task automatic poll();
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      xfer(1'b0, 1'b1, 8'h00, s);
      n++;
    end while (s[7] !== 1'b0 && n < 100);
    if (s[7] !== 1'b0) hangs++;
    repeat (HALF_OSC) @(posedge mclk_i);
  endtask : poll
  task automatic cmd(input logic rs, input logic [7:0] v);
    logic [7:0] r;
    poll();
    xfer(rs, 1'b0, v, r);
  endtask : cmd
  task automatic rd(output logic [7:0] r);
    poll();
    xfer(1'b1, 1'b1, 8'h00, r);
  endtask : rd
endmodule : lcd_host_model

/* File: dv/testbench.sv */
// Self-checking bench of the display instruction decoder
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] mask;
    logic [7:0] cfg;
    logic [7:0] ac;
  } row_t;
  row_t rows [12] = '{'{8'h07, 8'h18, 8'h18, 8'h00},
    '{8'h06, 8'h18, 8'h10, 8'h00}, '{8'h0f, 8'he0, 8'he0, 8'h00},
    '{8'h0a, 8'he0, 8'h40, 8'h00}, '{8'h38, 8'h07, 8'h06, 8'h00},
    '{8'h34, 8'h07, 8'h05, 8'h00}, '{8'hc5, 8'h00, 8'h00, 8'h45},
    '{8'h6a, 8'h00, 8'h00, 8'h2a}, '{8'h14, 8'h00, 8'h00, 8'h2b},
    '{8'h10, 8'h00, 8'h00, 8'h2a}, '{8'h1c, 8'h00, 8'h00, 8'h2a},
    '{8'h02, 8'h00, 8'h00, 8'h00}};
  logic mclk_i;
  logic rst_i;
  logic en;
  logic rs;
  logic rw;
  logic [7:0] wr;
  logic [7:0] rd;
  logic oe;
  lcd_pkg::cfg_t cfg;
  logic busy;
  logic [6:0] ac;
  logic [6:0] shift;
  logic [7:0] r;
  int miscompares = 0;
  int comparisons = 0;
  lcd_host_model host (.mclk_i, .rd_i(rd), .en_o(en), .rs_o(rs),
    .rw_o(rw), .wr_o(wr));
  lcd_decoder #(.LONG_CYC(60), .SHORT_CYC(20), .DATA_CYC(30)) uut (
    .mclk_i, .rst_i, .en_i(en), .register_select_i(rs), .rw_i(rw),
    .db_i(wr), .db_o(rd), .db_oe_o(oe), .cfg_o(cfg), .busy_flag_o(busy),
    .address_counter_o(ac), .display_shift_o(shift));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    miscompares += host.hangs;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // ***************
  // Main sequence
  // ***************
  initial begin
    rst_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    chk({busy, ac}, 8'h00);
    chk({6'h00, cfg.bus_width_select, cfg.dir_inc}, 8'h02);
    foreach (rows[i]) begin
      host.cmd(1'b0, rows[i].code);
      host.poll();
      chk(cfg & rows[i].mask, rows[i].cfg);
      chk({1'b0, ac}, rows[i].ac);
    end
    chk({1'b0, shift}, 8'h00);
    host.cmd(1'b0, 8'h90);
    host.cmd(1'b1, 8'h5a);
    host.cmd(1'b1, 8'ha5);
    host.poll();
    chk({1'b0, ac}, 8'h12);
    host.cmd(1'b0, 8'h90);
    host.rd(r);
    host.rd(r);
    chk(r, 8'h5a);
    host.rd(r);
    chk(r, 8'ha5);
    host.cmd(1'b0, 8'h04);
    host.cmd(1'b1, 8'h33);
    host.poll();
    chk({1'b0, ac}, 8'h12);
    host.cmd(1'b0, 8'h43);
    host.cmd(1'b1, 8'h1f);
    host.cmd(1'b0, 8'h43);
    host.rd(r);
    host.rd(r);
    chk(r, 8'h1f);
    host.cmd(1'b0, 8'h07);
    host.cmd(1'b0, 8'h80);
    host.cmd(1'b1, 8'h41);
    host.poll();
    chk({1'b0, shift}, 8'h7f);
    chk({1'b0, ac}, 8'h01);
    host.cmd(1'b0, 8'h01);
    host.xfer(1'b0, 1'b1, 8'h00, r);
    chk({7'h00, r[7]}, 8'h01);
    host.xfer(1'b1, 1'b0, 8'h77, r);
    host.poll();
    chk({1'b0, ac}, 8'h00);
    chk({7'h00, cfg.dir_inc}, 8'h01);
    host.cmd(1'b0, 8'h90);
    host.rd(r);
    host.rd(r);
    chk(r, 8'h20);
    host.cmd(1'b0, 8'h28);
    host.wide = 1'b0;
    host.poll();
    chk({7'h00, cfg.bus_width_select}, 8'h00);
    host.cmd(1'b0, 8'hb3);
    host.poll();
    host.xfer(1'b0, 1'b1, 8'h00, r);
    chk(r, 8'h33);
    give_verdict();
  end
endmodule : testbench
